// ==== shared/fsup_pkg.sv ====
// Purpose: constants and types for the fault supervisor and thermal monitor
// Assumes: one clock (mclk_i), asynchronous active-low reset
// Notes: registers are reached through a plain byte-wide read port at printed offsets
package fsup_pkg;
    localparam int          FSUP_NCH         = 8;
    localparam int          FSUP_NFLT        = 12;
    localparam logic [7:0]  FSUP_OFS_FLT_LO  = 8'h38;
    localparam logic [7:0]  FSUP_OFS_FLT_HI  = 8'h39;
    localparam logic [7:0]  FSUP_OFS_REG_LO  = 8'h3a;
    localparam logic [7:0]  FSUP_OFS_REG_HI  = 8'h3b;
    localparam logic [7:0]  FSUP_RST_BYTE    = 8'h00;
    localparam int          FSUP_TSD_DEGC    = 170;
    localparam int          FSUP_HYST_DEGC   = 20;
    localparam logic [7:0]  FSUP_TEMP_TSD    = 8'd170;
    localparam logic [7:0]  FSUP_TEMP_RESUME = FSUP_TEMP_TSD - 8'd20;
    localparam logic [7:0]  FSUP_TEMP_DERATE = FSUP_TEMP_TSD - 8'd20;
    localparam logic [7:0]  FSUP_CUR_FULL    = 8'hff;
    // fault numbers, bit positions in the 12-bit fault word
    localparam int F_IN_OC   = 0;
    localparam int F_SW_OC   = 1;
    localparam int F_SW_OV   = 2;
    localparam int F_OUT_UV  = 3;
    localparam int F_FREQUENCY_SET_PIN    = 4;
    localparam int F_SYNC    = 5;
    localparam int F_TSD     = 6;
    localparam int F_OVP     = 7;
    localparam int F_OPEN    = 8;
    localparam int F_SHORT   = 9;
    localparam int F_GND     = 10;
    localparam int F_TWARN   = 11;
    localparam logic [11:0] FSUP_NO_RETRY = 12'h607;
    localparam logic [11:0] FSUP_RST_LATCH = 12'h000;
    typedef enum logic [3:0] {
        FSUP_IDLE  = 4'b0001,
        FSUP_CHECK = 4'b0010,
        FSUP_RUN   = 4'b0100,
        FSUP_HALT  = 4'b1000
    } fsup_state_t;
endpackage : fsup_pkg

// ==== shared/fsup_sync_if.sv ====
// Purpose: carrier for raw and synchronised analog indications
// Assumes: same clock on both modports
// Notes: none
`timescale 1ns/100ps
`default_nettype none
interface fsup_sync_if #(parameter int W = 32);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport src (output raw, input sync);
    modport dst (input raw, output sync);
endinterface : fsup_sync_if
`default_nettype wire

// ==== rtl/fsup_sync.sv ====
// Purpose: two-flop synchroniser for comparator levels
// Assumes: levels are slow compared to the clock
// Notes: first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module fsup_sync #(parameter int W = 32)
(
    input  wire logic  mclk_i,
    input  wire logic  arst_n_i,
    fsup_sync_if.dst   bus
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fsup_sy_t;
    fsup_sy_t st_r;
    fsup_sy_t st_nxt;
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = bus.raw;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign bus.sync = st_r.s2;
endmodule : fsup_sync
`default_nettype wire

// ==== rtl/fsup_flags.sv ====
// Purpose: sticky fault flags with per-fault latch or auto-restart clear
// Assumes: inputs already synchronised
// Notes: a set in the clear cycle wins
`timescale 1ns/100ps
`default_nettype none
module fsup_flags #(parameter int N = 12)
(
    input  wire logic         mclk_i,
    input  wire logic         arst_n_i,
    input  wire logic [N-1:0] cond_i,
    input  wire logic [N-1:0] latch_mode_i,
    input  wire logic [N-1:0] clear_i,
    output logic      [N-1:0] flag_o
);
    typedef struct packed {
        logic [N-1:0] flag;
    } fsup_fl_t;
    fsup_fl_t st_r;
    fsup_fl_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        // latched flags drop only on controller clear; auto ones when cause is gone
        st_nxt.flag = cond_i | (st_r.flag & ~((clear_i & latch_mode_i)
                      | (~latch_mode_i & ~cond_i)));
    end
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign flag_o = st_r.flag;
endmodule : fsup_flags
`default_nettype wire

// ==== rtl/fsup_top.sv ====
// Purpose: fault supervision, status registers, status outputs, thermal handling
// Assumes: comparator and temperature inputs are asynchronous to mclk_i
// Notes: derating is a linear current scale, a simplification of the analog curve
`timescale 1ns/100ps
`default_nettype none
module fsup_top
(
    input  wire logic                          mclk_i,
    input  wire logic                          arst_n_i,
    input  wire logic                          enable_i,
    input  wire logic                          out_uv_i,
    input  wire logic                          sw_oc2_i,
    input  wire logic                          sw_ov2_i,
    input  wire logic                          in_oc_i,
    input  wire logic                          overvoltage_trip_i,
    input  wire logic [fsup_pkg::FSUP_NCH-1:0] chan_reg_i,
    input  wire logic [fsup_pkg::FSUP_NCH-1:0] chan_gnd_i,
    input  wire logic [fsup_pkg::FSUP_NCH-1:0] chan_drop_i,
    input  wire logic                          frequency_set_pin_fault_i,
    input  wire logic                          sync_present_i,
    input  wire logic                          sw_ilim_i,
    input  wire logic                          temp_warn_i,
    input  wire logic [7:0]                    die_temp_i,
    input  wire logic [fsup_pkg::FSUP_NCH-1:0] chan_en_i,
    input  wire logic [11:0]                   latch_mode_i,
    input  wire logic [11:0]                   fault_clear_i,
    input  wire logic                          derate_en_i,
    input  wire logic [3:0]                    sel_one_i,
    input  wire logic [3:0]                    sel_two_i,
    input  wire logic [7:0]                    rd_addr_i,
    input  wire logic                          rd_en_i,
    output logic [7:0]                         rd_data_o,
    output logic                               boost_en_o,
    output logic                               input_switch_on_o,
    output logic [fsup_pkg::FSUP_NCH-1:0]      chan_drive_o,
    output logic                               use_ext_sync_o,
    output logic [7:0]                         chan_scale_o,
    output logic                               fault_flag_o,
    output logic                               status_output_one_o,
    output logic                               status_output_one_oe_o,
    output logic                               status_output_two_o,
    output logic                               status_output_two_oe_o
);
    import fsup_pkg::*;

    localparam int SW = 9 + 3 * FSUP_NCH + 8;

    // raw bundle, then synchronised copy
    fsup_sync_if #(.W(SW)) sif ();
    assign sif.raw = {die_temp_i, chan_drop_i, chan_gnd_i, chan_reg_i, temp_warn_i,
                      sw_ilim_i, sync_present_i, frequency_set_pin_fault_i, overvoltage_trip_i,
                      in_oc_i, sw_ov2_i, sw_oc2_i, out_uv_i};

    fsup_sync #(.W(SW)) u_sync
    (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .bus      (sif)
    );

    logic [7:0]          s_temp;
    logic [FSUP_NCH-1:0] s_drop;
    logic [FSUP_NCH-1:0] s_gnd;
    logic [FSUP_NCH-1:0] s_reg;
    logic                s_twarn;
    logic                s_ilim;
    logic                s_sync;
    logic                s_frequency_set_pin;
    logic                s_ovp;
    logic                s_inoc;
    logic                s_swov;
    logic                s_swoc;
    logic                s_uv;
    assign {s_temp, s_drop, s_gnd, s_reg, s_twarn, s_ilim, s_sync, s_frequency_set_pin, s_ovp,
            s_inoc, s_swov, s_swoc, s_uv} = sif.sync;

    typedef struct packed {
        fsup_state_t         state;
        logic [FSUP_NCH-1:0] removed;
        logic [FSUP_NCH-1:0] gnd_seen;
        logic                thermal_shutdown_event;
        logic                in_off;
        logic                recheck;
        logic [7:0]          rd_data;
        logic                boost;
        logic                inswitch;
        logic [FSUP_NCH-1:0] drive;
        logic                extsync;
        logic [7:0]          scale;
        logic                flag;
        logic                one_oe;
        logic                two_oe;
    } fsup_top_t;

    fsup_top_t st_r;
    fsup_top_t st_nxt;

    logic [11:0] cond;
    logic [11:0] flags;
    logic        tsd_now;
    logic        open_ev;
    logic        gnd_ev;
    logic [FSUP_NCH-1:0] unreg;

    function automatic logic pick(input logic [3:0] sel, input logic [11:0] f);
        pick = (sel < 4'd12) ? f[sel] : 1'b0;
    endfunction : pick

    function automatic logic [7:0] fbyte(input logic hi, input logic [11:0] f);
        fbyte = hi ? {4'h0, f[11:8]} : f[7:0];
    endfunction : fbyte

    // clamp at shutdown so the product cannot wrap back to a high scale
    function automatic logic [7:0] derate(input logic [7:0] t);
        logic [7:0] c;
        c      = (t > FSUP_TEMP_TSD) ? FSUP_TEMP_TSD : t;
        derate = FSUP_CUR_FULL - 8'((c - FSUP_TEMP_DERATE) * 8'd12);
    endfunction : derate

    assign unreg   = chan_en_i & ~s_reg & ~st_r.removed;
    assign open_ev = s_ovp && ((unreg & ~s_gnd) != '0);
    assign gnd_ev  = s_ovp && ((unreg & s_gnd) != '0);
    assign tsd_now = st_r.thermal_shutdown_event ? (s_temp > FSUP_TEMP_RESUME) : (s_temp >= FSUP_TEMP_TSD);

    always_comb
    begin
        cond           = '0;
        cond[F_IN_OC]  = s_inoc;
        cond[F_SW_OC]  = s_swoc;
        cond[F_SW_OV]  = s_swov;
        cond[F_OUT_UV] = s_uv;
        cond[F_FREQUENCY_SET_PIN]   = s_frequency_set_pin;
        cond[F_SYNC]   = ~s_sync;
        cond[F_TSD]    = tsd_now;
        cond[F_OVP]    = s_ovp && !open_ev;
        cond[F_OPEN]   = open_ev;
        cond[F_SHORT]  = (s_drop & chan_en_i) != '0;
        cond[F_GND]    = gnd_ev || (st_r.state == FSUP_CHECK && s_gnd != '0);
        cond[F_TWARN]  = s_twarn | s_ilim;
    end

    // no-retry faults are forced latching regardless of mode
    fsup_flags #(.N(FSUP_NFLT)) u_flags
    (
        .mclk_i       (mclk_i),
        .arst_n_i     (arst_n_i),
        .cond_i       (cond),
        .latch_mode_i (latch_mode_i | FSUP_NO_RETRY),
        .clear_i      (fault_clear_i),
        .flag_o       (flags)
    );

    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.thermal_shutdown_event = tsd_now;
        if (s_inoc && st_r.state != FSUP_RUN)
            st_nxt.in_off = 1'b1;
        else if (st_r.state == FSUP_IDLE && !flags[F_IN_OC])
            st_nxt.in_off = 1'b0;
        st_nxt.removed  = st_r.removed | (s_ovp ? (unreg & ~s_gnd) : '0)
                          | (s_drop & chan_en_i);
        st_nxt.gnd_seen = st_r.gnd_seen | (s_ovp ? (unreg & s_gnd) : '0);
        case (st_r.state)
            FSUP_IDLE:
            begin
                if (enable_i && flags[2:0] == 3'b000 && !flags[F_FREQUENCY_SET_PIN] && !flags[F_GND])
                    st_nxt.state = FSUP_CHECK;
            end
            FSUP_CHECK:
            begin
                // hold here while a pin is grounded or the output is undervoltage
                if (s_gnd == '0 && !s_uv && !s_frequency_set_pin && !tsd_now)
                begin
                    st_nxt.state   = FSUP_RUN;
                    st_nxt.recheck = 1'b0;
                end
                if (!enable_i)
                    st_nxt.state = FSUP_IDLE;
            end
            FSUP_RUN:
            begin
                if (s_swoc || s_swov || gnd_ev || s_inoc)
                    st_nxt.state = FSUP_HALT;
                else if (s_frequency_set_pin || tsd_now)
                    st_nxt.state = FSUP_CHECK;
                if (gnd_ev)
                    st_nxt.recheck = 1'b1;
                if (!enable_i)
                    st_nxt.state = FSUP_IDLE;
            end
            FSUP_HALT:
            begin
                // leave once the controller cleared the input OC, switch OC, switch OV and ground flags, or on disable while the ground flag is clear
                if (flags[2:0] == 3'b000 && !flags[F_GND])
                    st_nxt.state = st_r.recheck ? FSUP_CHECK : FSUP_IDLE;
                if (!enable_i && !flags[F_GND])
                    st_nxt.state = FSUP_IDLE;
            end
            default:
            begin
                st_nxt.state = FSUP_IDLE;
            end
        endcase
        if (!enable_i && st_r.state == FSUP_IDLE)
        begin
            st_nxt.removed  = '0;
            st_nxt.gnd_seen = '0;
        end
        st_nxt.boost    = (st_r.state == FSUP_RUN) && !tsd_now;
        st_nxt.inswitch = enable_i && !st_nxt.in_off;
        st_nxt.drive    = (st_r.state == FSUP_RUN && !tsd_now) ? (chan_en_i & ~st_nxt.removed)
                          : '0;
        st_nxt.extsync  = s_sync;
        if (derate_en_i && s_temp > FSUP_TEMP_DERATE)
            st_nxt.scale = derate(s_temp);
        else
            st_nxt.scale = FSUP_CUR_FULL;
        st_nxt.flag     = (flags & ~(12'h1 << F_TWARN)) != '0;
        // outputs pull low when the selected bit is set
        st_nxt.one_oe   = pick(sel_one_i, flags);
        st_nxt.two_oe   = pick(sel_two_i, flags);
        st_nxt.rd_data  = st_r.rd_data;
        if (rd_en_i)
        begin
            case (rd_addr_i)
                FSUP_OFS_FLT_LO: st_nxt.rd_data = fbyte(1'b0, flags);
                FSUP_OFS_FLT_HI: st_nxt.rd_data = fbyte(1'b1, flags);
                FSUP_OFS_REG_LO: st_nxt.rd_data = st_r.removed;
                FSUP_OFS_REG_HI: st_nxt.rd_data = st_r.gnd_seen;
                default:         st_nxt.rd_data = FSUP_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_r         <= '0;
            st_r.state   <= FSUP_IDLE;
            st_r.scale   <= FSUP_CUR_FULL;
            st_r.extsync <= 1'b0;
        end
        else
            st_r <= st_nxt;
    end

    assign rd_data_o              = st_r.rd_data;
    assign boost_en_o             = st_r.boost;
    assign input_switch_on_o      = st_r.inswitch;
    assign chan_drive_o           = st_r.drive;
    assign use_ext_sync_o         = st_r.extsync;
    assign chan_scale_o           = st_r.scale;
    assign fault_flag_o           = st_r.flag;
    assign status_output_one_o    = 1'b0;
    assign status_output_one_oe_o = st_r.one_oe;
    assign status_output_two_o    = 1'b0;
    assign status_output_two_oe_o = st_r.two_oe;

    property p_no_retry;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (st_r.state == FSUP_RUN && s_swoc && enable_i) |=> st_r.state == FSUP_HALT;
    endproperty
    a_no_retry: assert property (p_no_retry) else $error("swoc did not halt");

    property p_ov_halt;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (st_r.state == FSUP_RUN && s_swov && enable_i) |=> st_r.state == FSUP_HALT;
    endproperty
    a_ov_halt: assert property (p_ov_halt) else $error("swov did not halt");

    property p_uv_hold;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (st_r.state == FSUP_CHECK && s_uv && enable_i) |=> st_r.state != FSUP_RUN;
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("startup past undervoltage");

    property p_gnd_hold;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (st_r.state == FSUP_CHECK && s_gnd != '0) |=> st_r.state != FSUP_RUN;
    endproperty
    a_gnd_hold: assert property (p_gnd_hold) else $error("startup past ground short");

    property p_inoc;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (s_inoc && st_r.state == FSUP_CHECK) |=> ##1 !input_switch_on_o;
    endproperty
    a_inoc: assert property (p_inoc) else $error("input switch stayed on");

    property p_tsd_off;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (s_temp >= FSUP_TEMP_TSD) |=> !boost_en_o && chan_drive_o == '0;
    endproperty
    a_tsd_off: assert property (p_tsd_off) else $error("drivers on above shutdown");

    property p_derate_off;
        @(posedge mclk_i) disable iff (!arst_n_i)
        !derate_en_i |=> chan_scale_o == FSUP_CUR_FULL;
    endproperty
    a_derate_off: assert property (p_derate_off) else $error("derated while disabled");

    property p_open_rm;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (s_ovp && (unreg & ~s_gnd) != '0 && enable_i) |=> (st_r.removed & $past(unreg & ~s_gnd))
                                                          == $past(unreg & ~s_gnd);
    endproperty
    a_open_rm: assert property (p_open_rm) else $error("open channel kept");

    property p_sync;
        @(posedge mclk_i) disable iff (!arst_n_i)
        !s_sync |=> !use_ext_sync_o;
    endproperty
    a_sync: assert property (p_sync) else $error("no fallback to resistor frequency");

    property p_gnd_halt;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (st_r.state == FSUP_RUN && gnd_ev && enable_i)
            |=> st_r.state == FSUP_HALT && st_r.recheck;
    endproperty
    a_gnd_halt: assert property (p_gnd_halt) else $error("ground short did not halt");

    property p_frequency_set_pin_block;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (st_r.state == FSUP_IDLE && flags[F_FREQUENCY_SET_PIN]) |=> st_r.state == FSUP_IDLE;
    endproperty
    a_frequency_set_pin_block: assert property (p_frequency_set_pin_block) else $error("start on pin fault");

    property p_warn_pin;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (flags[F_TWARN] && sel_two_i == 4'hb) |=> status_output_two_oe_o;
    endproperty
    a_warn_pin: assert property (p_warn_pin) else $error("warning not on pin");

    property p_drop_off;
        @(posedge mclk_i) disable iff (!arst_n_i)
        ((s_drop & chan_en_i) != '0) |=> (chan_drive_o & $past(s_drop & chan_en_i)) == '0;
    endproperty
    a_drop_off: assert property (p_drop_off) else $error("shorted string kept");

    property p_tsd_resume;
        @(posedge mclk_i) disable iff (!arst_n_i)
        (st_r.thermal_shutdown_event && s_temp > FSUP_TEMP_RESUME) |=> !boost_en_o && chan_drive_o == '0;
    endproperty
    a_tsd_resume: assert property (p_tsd_resume) else $error("restart before cooling");
endmodule : fsup_top
`default_nettype wire

// ==== tb/fsup_ctrl_model.sv ====
// Purpose: system controller side of the two status lines
// Assumes: open-drain outputs, oe high means the device pulls low
// Notes: pull-ups give the high level, so a released line never floats
`timescale 1ns/100ps
`default_nettype none
module fsup_ctrl_model
(
    input  wire logic oe_one_i,
    input  wire logic oe_two_i,
    output logic      line_one_o,
    output logic      line_two_o
);
    // resistor pull-up on each line, device only pulls low
    assign line_one_o = oe_one_i ? 1'b0 : 1'b1;
    assign line_two_o = oe_two_i ? 1'b0 : 1'b1;
endmodule : fsup_ctrl_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the fault supervisor
// Assumes: flags show within 8 cycles of a cause, states within 10
// Notes: per-fault table first, then run-time cases by hand
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module testbench;
    import fsup_pkg::*;
    typedef struct { int idx; logic [7:0] lo; logic [7:0] hi; } fsup_row_t;
    logic mclk_i = 0, arst_n_i = 0, enable_i = 0, out_uv_i = 0, sw_oc2_i = 0, sw_ov2_i = 0;
    logic in_oc_i = 0, overvoltage_trip_i = 0, frequency_set_pin_fault_i = 0, sync_present_i = 1;
    logic sw_ilim_i = 0, temp_warn_i = 0, derate_en_i = 0, rd_en_i = 0;
    logic [7:0] chan_reg_i = 8'hff, chan_gnd_i = 8'h00, chan_drop_i = 8'h00;
    logic [7:0] die_temp_i = 8'h19, chan_en_i = 8'hff, rd_addr_i = 8'h00, rd_data_o, d;
    logic [11:0] latch_mode_i = 12'h000, fault_clear_i = 12'h000;
    logic [3:0] sel_one_i = 4'hf, sel_two_i = 4'hf;
    logic [7:0] chan_drive_o, chan_scale_o;
    logic boost_en_o, input_switch_on_o, use_ext_sync_o, fault_flag_o, line_one, line_two;
    logic st_one_o, st_one_oe_o, st_two_o, st_two_oe_o;
    int num_errors = 0, check_count = 0, cycles = 0;
    fsup_row_t rows[11] = '{'{0, 8'h01, 8'h00}, '{1, 8'h02, 8'h00}, '{2, 8'h04, 8'h00},
        '{3, 8'h08, 8'h00}, '{4, 8'h10, 8'h00}, '{5, 8'h20, 8'h00}, '{6, 8'h40, 8'h00},
        '{7, 8'h80, 8'h00}, '{9, 8'h00, 8'h02}, '{10, 8'h00, 8'h04}, '{11, 8'h00, 8'h08}};
    fsup_top uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .enable_i(enable_i),
        .out_uv_i(out_uv_i), .sw_oc2_i(sw_oc2_i), .sw_ov2_i(sw_ov2_i), .in_oc_i(in_oc_i),
        .overvoltage_trip_i(overvoltage_trip_i), .chan_reg_i(chan_reg_i),
        .chan_gnd_i(chan_gnd_i), .chan_drop_i(chan_drop_i), .frequency_set_pin_fault_i(frequency_set_pin_fault_i),
        .sync_present_i(sync_present_i), .sw_ilim_i(sw_ilim_i), .temp_warn_i(temp_warn_i),
        .die_temp_i(die_temp_i), .chan_en_i(chan_en_i), .latch_mode_i(latch_mode_i),
        .fault_clear_i(fault_clear_i), .derate_en_i(derate_en_i), .sel_one_i(sel_one_i),
        .sel_two_i(sel_two_i), .rd_addr_i(rd_addr_i), .rd_en_i(rd_en_i),
        .rd_data_o(rd_data_o), .boost_en_o(boost_en_o), .input_switch_on_o(input_switch_on_o),
        .chan_drive_o(chan_drive_o), .use_ext_sync_o(use_ext_sync_o),
        .chan_scale_o(chan_scale_o), .fault_flag_o(fault_flag_o),
        .status_output_one_o(st_one_o), .status_output_one_oe_o(st_one_oe_o),
        .status_output_two_o(st_two_o), .status_output_two_oe_o(st_two_oe_o));
    fsup_ctrl_model ctrl (.oe_one_i(st_one_oe_o), .oe_two_i(st_two_oe_o),
        .line_one_o(line_one), .line_two_o(line_two));
    initial forever #4 mclk_i = ~mclk_i;
    // generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic look(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : look
    // read is taken on the edge with rd_en high, data lands on that same edge
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        rd_addr_i <= a;
        rd_en_i   <= 1'b1;
        @(posedge mclk_i);
        rd_en_i   <= 1'b0;
        @(negedge mclk_i);
        d = rd_data_o;
    endtask : rd
    task automatic cause(input int i, input logic on);
        @(posedge mclk_i);
        case (i)
            0: in_oc_i <= on;
            1: sw_oc2_i <= on;
            2: sw_ov2_i <= on;
            3: out_uv_i <= on;
            4: frequency_set_pin_fault_i <= on;
            5: sync_present_i <= !on;
            6: die_temp_i <= on ? 8'd170 : 8'h19;
            7: overvoltage_trip_i <= on;
            9: chan_drop_i <= {7'h00, on};
            10:
            begin
                chan_gnd_i <= {7'h00, on};
                if (on)
                    repeat (3) @(posedge mclk_i);
                enable_i <= on;
            end
            default: temp_warn_i <= on;
        endcase
    endtask : cause
    task automatic clr();
        @(posedge mclk_i);
        fault_clear_i <= 12'hfff;
        @(posedge mclk_i);
        fault_clear_i <= 12'h000;
    endtask : clr
    initial
    begin
        repeat (12) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        look(2);
        `CHK("boost", 1'b0, boost_en_o)
        `CHK("scale", 8'hff, chan_scale_o)
        rd(8'h55);
        `CHK("unmapped", 8'h00, d)
        foreach (rows[r])
        begin
            @(posedge mclk_i);
            sel_one_i <= 4'(rows[r].idx);
            cause(rows[r].idx, 1'b1);
            look(8);
            `CHK("oe_one", 1'b1, st_one_oe_o)
            `CHK("line_one", 1'b0, line_one)
            `CHK("pin_one", 1'b0, st_one_o)
            rd(FSUP_OFS_FLT_LO);
            `CHK("flt_lo", rows[r].lo, d)
            rd(FSUP_OFS_FLT_HI);
            `CHK("flt_hi", rows[r].hi, d)
            cause(rows[r].idx, 1'b0);
            look(4);
            clr();
            look(4);
            rd(FSUP_OFS_FLT_LO);
            `CHK("cleared", 8'h00, d)
        end
        cause(3, 1'b1);
        repeat (4) @(posedge mclk_i);
        enable_i <= 1'b1;
        look(10);
        `CHK("uv_hold", 1'b0, boost_en_o)
        cause(3, 1'b0);
        look(12);
        `CHK("run", 1'b1, boost_en_o)
        `CHK("drive", 8'hff, chan_drive_o)
        `CHK("insw", 1'b1, input_switch_on_o)
        `CHK("ext", 1'b1, use_ext_sync_o)
        cause(5, 1'b1);
        look(8);
        `CHK("int_freq", 1'b0, use_ext_sync_o)
        cause(5, 1'b0);
        sel_two_i <= 4'hb;
        cause(11, 1'b1);
        look(8);
        `CHK("warn_pin", 1'b0, line_two)
        `CHK("warn_run", 1'b1, boost_en_o)
        cause(11, 1'b0);
        die_temp_i <= 8'd160;
        look(8);
        `CHK("no_derate", 8'hff, chan_scale_o)
        @(posedge mclk_i);
        derate_en_i <= 1'b1;
        look(8);
        `CHK("derate", 8'h87, chan_scale_o)
        @(posedge mclk_i);
        derate_en_i <= 1'b0;
        die_temp_i <= 8'd170;
        look(10);
        `CHK("tsd_boost", 1'b0, boost_en_o)
        `CHK("tsd_drive", 8'h00, chan_drive_o)
        @(posedge mclk_i);
        die_temp_i <= 8'd151;
        look(10);
        `CHK("tsd_hold", 1'b0, boost_en_o)
        @(posedge mclk_i);
        die_temp_i <= 8'd150;
        look(14);
        `CHK("tsd_resume", 1'b1, boost_en_o)
        cause(4, 1'b1);
        look(10);
        `CHK("frequency_set_pin_stop", 1'b0, boost_en_o)
        cause(4, 1'b0);
        look(14);
        `CHK("auto_restart", 1'b1, boost_en_o)
        @(posedge mclk_i);
        chan_drop_i <= 8'h04;
        look(10);
        `CHK("drop_one", 8'hfb, chan_drive_o)
        chan_drop_i <= 8'h00;
        cause(1, 1'b1);
        look(10);
        `CHK("oc_stop", 1'b0, boost_en_o)
        cause(1, 1'b0);
        look(14);
        `CHK("no_retry", 1'b0, boost_en_o)
        clr();
        look(14);
        `CHK("after_clear", 1'b1, boost_en_o)
        @(posedge mclk_i);
        chan_reg_i <= 8'hef;
        cause(7, 1'b1);
        look(4);
        cause(7, 1'b0);
        look(8);
        `CHK("open_off", 1'b0, chan_drive_o[4])
        `CHK("flag_clear", 1'b0, fault_flag_o)
        rd(FSUP_OFS_REG_LO);
        `CHK("removed", 8'h10, d & 8'h10)
        cause(0, 1'b1);
        look(10);
        `CHK("insw_off", 1'b0, input_switch_on_o)
        summarize();
    end
endmodule : testbench
`default_nettype wire
